// file: logic/smsp_map.vh
// Purpose: Constants for the message-stream SPI slave port.
// Assumes: Included once by the design files.
// Notes: Timing counts derive from times and the core clock rate.
`ifndef SMSP_MAP_VH
`define SMSP_MAP_VH
`define SMSP_FILLER 8'hff
`define SMSP_FILLER_RUN 6'd50
`define SMSP_CLK_HZ 50000000
`define SMSP_IDLE_MS 2000
`define SMSP_IDLE_CYC (`SMSP_CLK_HZ / 1000 * `SMSP_IDLE_MS)
`define SMSP_EXT_LIMIT 13'd4096
`define SMSP_SEL_SPI 1'b0
`define SMSP_BIT_MSB 3'd7
`define SMSP_BIT_LSB 3'd0
`endif

// file: logic/smsp_sync.v
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: Input comes from outside the core clock domain.
// Notes: Output changes once stages two and three agree.
module smsp_sync #(
   parameter INIT = 1'b1
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire din,
   output reg dout
);
   reg s1_reg; // First stage, read only by s2
   reg s2_reg; // Second stage
   reg s3_reg; // Third stage

   // Shift through three stages and update on agreement
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         dout <= INIT;
      end else if (ce) begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule

// file: logic/smsp_port.v
// Purpose: Slave-only SPI message-stream port with pin-select, pending
//    indicator and host-inactivity idling.
// Assumes: SPI mode 0, host samples on rising link clock edge;
//    SPI clock sampled by CORE_CLK, much faster than the link.
// Notes:
`include "smsp_map.vh"
module smsp_port #(
   parameter IDLE_CYCLES = `SMSP_IDLE_CYC,
   parameter CNT_W = 13,
   parameter PIN_W = 5
) (
   input wire CORE_CLK,
   input wire RESET,
   input wire CE,
   input wire PIN_SELECT,
   input wire PIN_CS_N_SDA_IN,
   input wire PIN_CLK_SCL_IN,
   input wire PIN_MOSI_RXD_IN,
   output reg PIN_MISO_TXD_OUT,
   output reg PIN_MISO_TXD_OE,
   output wire SERIAL_TXD,
   output wire SERIAL_TXD_EN,
   input wire SERIAL_TX_REQ,
   output wire SERIAL_RXD,
   output wire I2C_SDA_IN,
   output wire I2C_SCL_IN,
   input wire I2C_XFER,
   input wire [7:0] TX_DATA,
   input wire TX_VALID,
   output wire TX_READY,
   input wire [CNT_W-1:0] TX_PENDING,
   output reg [7:0] RX_DATA,
   output reg RX_VALID,
   output reg PARSE_ACTIVE,
   input wire CFG_WR,
   input wire CFG_IND_EN,
   input wire CFG_IND_POL,
   input wire [PIN_W-1:0] CFG_IND_PIN,
   input wire [CNT_W-1:0] CFG_IND_THR,
   input wire CFG_EXT_TIMEOUT,
   input wire IND_PIN_VALID,
   output reg CFG_RB_EN,
   output reg CFG_RB_POL,
   output reg [PIN_W-1:0] CFG_RB_PIN,
   output reg [CNT_W-1:0] CFG_RB_THR,
   output reg IND_OUT,
   output reg PORT_IDLE
);
   wire cs_s; // Synchronised chip select
   wire sck_s; // Synchronised SPI clock
   wire mosi_s; // Synchronised data in
   reg sck_d_reg; // Previous clock level for edges
   reg cs_d_reg; // Previous select level
   reg [2:0] bit_reg; // Bit index within the byte
   reg [7:0] sh_in_reg; // Receive shift register
   reg [7:0] sh_out_reg; // Transmit shift register
   reg [5:0] ff_run_reg; // Consecutive filler count
   reg [31:0] idle_reg; // Inactivity counter
   wire spi_mode; // Pins act as SPI
   wire sel; // Chip select active
   wire rise; // SPI clock rising edge
   wire [7:0] rx_byte; // Completed received byte
   wire byte_done; // Last bit sampled
   wire activity; // SPI byte done or I2C transfer

   smsp_sync #(.INIT(1'b1)) u_cs (.clk(CORE_CLK), .rst(RESET), .ce(CE),
      .din(PIN_CS_N_SDA_IN), .dout(cs_s));
   smsp_sync #(.INIT(1'b1)) u_sck (.clk(CORE_CLK), .rst(RESET), .ce(CE),
      .din(PIN_CLK_SCL_IN), .dout(sck_s));
   smsp_sync #(.INIT(1'b1)) u_mosi (.clk(CORE_CLK), .rst(RESET), .ce(CE),
      .din(PIN_MOSI_RXD_IN), .dout(mosi_s));

   // Pin-select steers shared pins; slave-only port
   assign spi_mode = (PIN_SELECT == `SMSP_SEL_SPI);
   assign SERIAL_RXD = spi_mode ? 1'b1 : PIN_MOSI_RXD_IN;
   assign I2C_SDA_IN = spi_mode ? 1'b1 : PIN_CS_N_SDA_IN;
   assign I2C_SCL_IN = spi_mode ? 1'b1 : PIN_CLK_SCL_IN;
   assign SERIAL_TXD = PIN_MISO_TXD_OUT;
   assign SERIAL_TXD_EN = ~spi_mode;
   assign sel = spi_mode & ~cs_s;
   assign rise = sel & sck_s & ~sck_d_reg;
   assign rx_byte = {sh_in_reg[6:0], mosi_s};
   assign byte_done = rise && (bit_reg == `SMSP_BIT_LSB);
   // Next queued byte taken as a byte starts, like a current-address read
   assign TX_READY = sel & ~cs_d_reg | byte_done;
   assign activity = byte_done | I2C_XFER;

   // Edge tracking
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         sck_d_reg <= 1'b1;
         cs_d_reg <= 1'b0;
      end else if (CE) begin
         sck_d_reg <= sck_s;
         cs_d_reg <= sel;
      end
   end

   // Full-duplex shift engine, MSB first
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         bit_reg <= `SMSP_BIT_MSB;
         sh_in_reg <= 8'h00;
         sh_out_reg <= `SMSP_FILLER;
         RX_DATA <= 8'h00;
         RX_VALID <= 1'b0;
      end else if (CE) begin
         RX_VALID <= 1'b0;
         if (!sel) begin
            bit_reg <= `SMSP_BIT_MSB;
         end else begin
            if (TX_READY) begin
               // Queued data, else filler byte
               sh_out_reg <= TX_VALID ? TX_DATA : `SMSP_FILLER;
            end else if (rise) begin
               // Next bit right after the sampled edge: the synchroniser
               // delay would miss a half period of a fast link clock
               sh_out_reg <= {sh_out_reg[6:0], 1'b1};
            end
            if (rise) begin
               sh_in_reg <= rx_byte;
               bit_reg <= bit_reg - 3'd1;
               if (byte_done) begin
                  // Only message bytes leave; nothing is addressable
                  RX_DATA <= rx_byte;
                  RX_VALID <= PARSE_ACTIVE | (rx_byte != `SMSP_FILLER);
               end
            end
         end
      end
   end

   // Output pin: data in SPI, serial transmit otherwise, high idle
   always @* begin
      if (spi_mode) begin
         PIN_MISO_TXD_OUT = sel ? sh_out_reg[7] : 1'b1;
         PIN_MISO_TXD_OE = sel;
      end else begin
         PIN_MISO_TXD_OUT = SERIAL_TX_REQ;
         PIN_MISO_TXD_OE = 1'b1;
      end
   end

   // Filler run tracking suspends and resumes parsing
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ff_run_reg <= 6'd0;
         PARSE_ACTIVE <= 1'b1;
      end else if (CE && byte_done) begin
         if (rx_byte != `SMSP_FILLER) begin
            ff_run_reg <= 6'd0;
            PARSE_ACTIVE <= 1'b1;
         end else if (ff_run_reg != `SMSP_FILLER_RUN) begin
            ff_run_reg <= ff_run_reg + 6'd1;
            if (ff_run_reg + 6'd1 == `SMSP_FILLER_RUN) begin
               PARSE_ACTIVE <= 1'b0;
            end
         end
      end
   end

   // Indicator configuration; bad pin rejects only indicator fields
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         CFG_RB_EN <= 1'b0;
         CFG_RB_POL <= 1'b0;
         CFG_RB_PIN <= {PIN_W{1'b0}};
         CFG_RB_THR <= {CNT_W{1'b0}};
      end else if (CE && CFG_WR) begin
         if (CFG_IND_EN && IND_PIN_VALID) begin
            CFG_RB_EN <= 1'b1;
            CFG_RB_POL <= CFG_IND_POL;
            CFG_RB_PIN <= CFG_IND_PIN;
            CFG_RB_THR <= CFG_IND_THR;
         end else begin
            CFG_RB_EN <= 1'b0;
            CFG_RB_POL <= 1'b0;
            CFG_RB_PIN <= {PIN_W{1'b0}};
            CFG_RB_THR <= {CNT_W{1'b0}};
         end
      end
   end

   // Pending indicator: set at threshold, held until queue empties
   reg ind_act_reg;
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ind_act_reg <= 1'b0;
         IND_OUT <= 1'b0;
      end else if (CE) begin
         if (!CFG_RB_EN) begin
            ind_act_reg <= 1'b0;
         end else if (TX_PENDING >= CFG_RB_THR && TX_PENDING != 0) begin
            ind_act_reg <= 1'b1;
         end else if (TX_PENDING == {CNT_W{1'b0}}) begin
            ind_act_reg <= 1'b0;
         end
         IND_OUT <= CFG_RB_EN ? (ind_act_reg ^ ~CFG_RB_POL) : 1'b0;
      end
   end

   // Inactivity timeout, restarted by an SPI byte or an I2C transfer
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         idle_reg <= 32'd0;
         PORT_IDLE <= 1'b0;
      end else if (CE) begin
         if (activity) begin
            idle_reg <= 32'd0;
            PORT_IDLE <= 1'b0;
         end else if (idle_reg < IDLE_CYCLES) begin
            idle_reg <= idle_reg + 32'd1;
         end else if (!CFG_EXT_TIMEOUT ||
                      TX_PENDING >= `SMSP_EXT_LIMIT) begin
            PORT_IDLE <= 1'b1;
         end
      end
   end
endmodule

// file: tb/smsp_port_properties.sv
// Purpose: Port-level checks for the message-stream SPI port.
// Assumes: CE held high; pins pass three-stage synchronisers.
// Notes: Bound from the bench top; waits cover synchroniser delay.
module smsp_port_properties #(
   parameter CNT_W = 13
) (
   input logic CORE_CLK,
   input logic RESET,
   input logic PIN_SELECT,
   input logic PIN_CS_N_SDA_IN,
   input logic PIN_MISO_TXD_OUT,
   input logic PIN_MISO_TXD_OE,
   input logic I2C_XFER,
   input logic [CNT_W-1:0] TX_PENDING,
   input logic [7:0] RX_DATA,
   input logic RX_VALID,
   input logic PARSE_ACTIVE,
   input logic CFG_WR,
   input logic CFG_IND_EN,
   input logic IND_PIN_VALID,
   input logic CFG_RB_EN,
   input logic CFG_RB_POL,
   input logic [CNT_W-1:0] CFG_RB_THR,
   input logic IND_OUT,
   input logic PORT_IDLE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   sel_serial_a: assert property (PIN_SELECT [*4] |-> PIN_MISO_TXD_OE)
      else $error("serial mode left output undriven");
   cs_idle_a: assert property ((!PIN_SELECT && PIN_CS_N_SDA_IN) [*6]
      |-> !PIN_MISO_TXD_OE && PIN_MISO_TXD_OUT) else $error("output not idle");
   ind_off_a: assert property (!CFG_RB_EN && !$past(CFG_RB_EN) |-> !IND_OUT)
      else $error("indicator active while disabled");
   cfg_reject_a: assert property (CFG_WR && !(CFG_IND_EN && IND_PIN_VALID)
      |=> !CFG_RB_EN && !CFG_RB_POL && CFG_RB_THR == 0) else $error("readback");
   ind_set_a: assert property ((CFG_RB_EN && TX_PENDING >= CFG_RB_THR
      && TX_PENDING != 0 && $stable(CFG_RB_POL)) [*3] |-> IND_OUT == CFG_RB_POL)
      else $error("indicator not active");
   ind_clear_a: assert property ((CFG_RB_EN && TX_PENDING == 0
      && $stable(CFG_RB_POL)) [*3] |-> IND_OUT != CFG_RB_POL)
      else $error("indicator not inactive");
   filler_stop_a: assert property (RX_VALID && !$past(PARSE_ACTIVE)
      |-> RX_DATA != 8'hff) else $error("filler parsed while suspended");
   idle_restart_a: assert property (I2C_XFER |-> ##[1:2] !PORT_IDLE)
      else $error("port idle after transfer");
   cover property (RX_VALID && RX_DATA == 8'hff);
   cover property ($rose(PORT_IDLE));
   cover property ($rose(IND_OUT));
endmodule

// file: tb/smsp_host.sv
// Purpose: Host SPI master model for the message-stream port.
// Assumes: Mode 0, 160 ns link clock, MSB first.
// Notes: Link clock stands still and MOSI idles high between frames.
module smsp_host (
   input logic miso,
   output logic cs_n,
   output logic sck,
   output logic mosi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cs_n, sck, mosi} = 3'b101; // Deselected, filler level
   // Select or deselect, then let the port settle
   task automatic sel(input logic v);
      cs_n = v;
      #320;
   endtask
   // One byte each way, MSB first, sampled on rising edge
   task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         mosi = t[i];
         #80 sck = 1'b1;
         r[i] = miso;
         #80 sck = 1'b0;
      end
      mosi = 1'b1; // Back to filler level
   endtask
endmodule

// file: tb/smsp_port_test.sv
// Purpose: Self-checking bench for the message-stream SPI port.
// Assumes: Short idle timeout; CE, pin and threshold inputs tied.
// Notes: Queued bytes, filler runs, pin select, indicator, idling.
module smsp_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, psel = 0, i2c = 0, tk = 0, tx_valid = 0;
   logic cfg_wr = 0, cfg_en = 0, cfg_pol = 0, pin_ok = 0, ce = 1;
   logic txreq = 0, ext = 0;
   logic [7:0] tx_data = 0, rx_data;
   logic [12:0] pend = 0, rb_thr;
   logic [4:0] rb_pin;
   logic cs_n, sck, mosi, miso_o, miso_oe, txd_en, rxd, sda, tx_ready;
   logic rx_valid, parse, rb_en, rb_pol, ind, idle;
   logic [7:0] txq[$], eo[$], ex[$], rxq[$]; // Queues of the model
   int err_total = 0, n_tests = 0, run = 0;
   integer seed = 32'h19bf7de1;
   always #10 clk = ~clk; // 50 MHz core clock
   smsp_host i_smsp_host (.miso(miso_oe ? miso_o : 1'b1), .cs_n(cs_n),
      .sck(sck), .mosi(mosi));
   smsp_port #(.IDLE_CYCLES(200)) i_smsp_port (.CORE_CLK(clk), .RESET(rst),
      .CE(ce), .PIN_SELECT(psel), .PIN_CS_N_SDA_IN(cs_n),
      .PIN_CLK_SCL_IN(sck), .PIN_MOSI_RXD_IN(mosi), .PIN_MISO_TXD_OUT(miso_o),
      .PIN_MISO_TXD_OE(miso_oe), .SERIAL_TXD(), .SERIAL_TXD_EN(txd_en),
      .SERIAL_TX_REQ(txreq), .SERIAL_RXD(rxd), .I2C_SDA_IN(sda),
      .I2C_SCL_IN(), .I2C_XFER(i2c), .TX_DATA(tx_data), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .TX_PENDING(pend), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .PARSE_ACTIVE(parse), .CFG_WR(cfg_wr),
      .CFG_IND_EN(cfg_en), .CFG_IND_POL(cfg_pol), .CFG_IND_PIN(5'h03),
      .CFG_IND_THR(13'h00a),
      .CFG_EXT_TIMEOUT(ext), .IND_PIN_VALID(pin_ok),
      .CFG_RB_EN(rb_en), .CFG_RB_POL(rb_pol), .CFG_RB_PIN(rb_pin),
      .CFG_RB_THR(rb_thr), .IND_OUT(ind), .PORT_IDLE(idle));
   // Feed queued bytes; advance after the port takes one
   always @(posedge clk) begin
      #2;
      if (tk) void'(txq.pop_front());
      tk = 1'b0;
      tx_valid = txq.size() != 0;
      tx_data = tx_valid ? txq[0] : 8'h00;
   end
   // Sample handshake and received bytes mid-cycle
   always @(negedge clk) begin
      if (tx_ready === 1'b1 && tx_valid) tk = 1'b1;
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
   end
   task automatic chk(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   // Exchange n bytes under one select, compare both directions
   task automatic frame(input int n, input logic ff);
      logic [7:0] t, r;
      i_smsp_host.sel(1'b0);
      repeat (n) begin
         t = ff ? 8'hff : 8'($random(seed));
         i_smsp_host.xbyte(t, r);
         chk(r, eo.size() ? eo.pop_front() : 8'hff, "out byte");
         run = t == 8'hff ? run + 1 : 0;
         if (run <= 50) ex.push_back(t);
      end
      i_smsp_host.sel(1'b1);
      chk(rxq.size(), ex.size(), "rx count");
      while (ex.size() && rxq.size())
         chk(rxq.pop_front(), ex.pop_front(), "rx byte");
      chk(parse, run < 50, "parse flag");
   endtask
   // Write indicator settings, check readback, let the pin follow
   task automatic cfg(input logic en, ok, pol);
      {cfg_wr, cfg_en, pin_ok, cfg_pol} = {1'b1, en, ok, pol};
      @(posedge clk) #2 cfg_wr = 0;
      chk({rb_en, rb_pol, rb_pin, rb_thr}, en && ok ?
         {1'b1, pol, 5'h03, 13'h00a} : 20'h0, "readback");
      repeat (3) @(posedge clk);
      #2;
   endtask
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      #2 rst = 0;
      chk({parse, ind, idle, rb_en}, 4'b1000, "reset state");
      repeat (4) txq.push_back(8'($random(seed)));
      eo = txq;
      frame(7, 0);
      $display("stream test done");
      frame(60, 1);
      frame(1, 0);
      $display("filler test done");
      psel = 1;
      txreq = 1;
      repeat (6) @(posedge clk);
      #2 chk({txd_en, miso_oe, rxd, sda}, 4'hf, "serial pins");
      chk(miso_o, txreq, "serial out");
      psel = 0;
      txreq = 0;
      pend = 20;
      cfg(1, 0, 1);
      chk(ind, 0, "invalid pin used");
      for (int p = 1; p >= 0; p--) begin
         cfg(1, 1, p[0]);
         chk(ind, p[0], "active level");
      end
      pend = 0;
      repeat (4) @(posedge clk);
      #2 chk(ind, 1, "inactive level");
      $display("indicator test done");
      repeat (2) begin
         i2c = 1;
         @(posedge clk) #2 i2c = 0;
         repeat (150) @(posedge clk);
         #2 chk(idle, 0, "idle too early");
      end
      repeat (70) @(posedge clk);
      #2 chk(idle, 1, "not idle");
      frame(1, 0);
      chk(idle, 0, "idle after byte");
      ext = 1;
      i2c = 1;
      @(posedge clk) #2 i2c = 0;
      repeat (220) @(posedge clk);
      #2 chk(idle, 0, "idle under limit");
      pend = 13'h1000;
      repeat (3) @(posedge clk);
      #2 chk(idle, 1, "idle at limit");
      ext = 0;
      pend = 0;
      $display("idle test done");
      print_verdict;
   end
   initial begin
      #400us;
      err_total++;
      print_verdict;
   end
endmodule
bind smsp_port smsp_port_properties #(.CNT_W(CNT_W)) i_smsp_port_properties (
   .CORE_CLK, .RESET, .PIN_SELECT, .PIN_CS_N_SDA_IN, .PIN_MISO_TXD_OUT,
   .PIN_MISO_TXD_OE, .I2C_XFER, .TX_PENDING, .RX_DATA, .RX_VALID,
   .PARSE_ACTIVE, .CFG_WR, .CFG_IND_EN, .IND_PIN_VALID, .CFG_RB_EN,
   .CFG_RB_POL, .CFG_RB_THR, .IND_OUT, .PORT_IDLE);
